// ---- fuse_pkg.sv ----
/*
 * fuse_pkg: constants and carrier types for the fp unordered-branch and
 * signaling-nan exception unit.
 * assumes: included before the unit; no other dependencies.
 */
package fuse_pkg;

	// exception status byte bit positions (bit 7 highest priority)
	localparam int EXC_UNORD   = 7;
	localparam int EXC_SIGNALING_NAN    = 6;
	localparam int EXC_OPERAND_ERROR   = 5;
	localparam int EXC_OVFL    = 4;
	localparam int EXC_UNFL    = 3;
	localparam int EXC_DZ      = 2;
	localparam int EXC_RESULT_INEXACT_FLAG   = 1;
	localparam int EXC_PACKED_INEXACT_FLAG   = 0;

	// vector numbers
	localparam logic [7:0] VEC_UNORD = 8'h30;  // 48
	localparam logic [7:0] VEC_SIGNALING_NAN  = 8'h36;  // 54
	localparam logic [7:0] VEC_OPERAND_ERROR = 8'h34;  // 52
	localparam logic [7:0] VEC_OVFL  = 8'h35;  // 53
	localparam logic [7:0] VEC_UNFL  = 8'h33;  // 51
	localparam logic [7:0] VEC_DZ    = 8'h32;  // 50
	localparam logic [7:0] VEC_INEX  = 8'h31;  // 49

	// stack frame formats
	localparam logic [3:0] FRAME_PRE  = 4'h0;
	localparam logic [3:0] FRAME_POST = 4'h3;

	// instruction encoding
	localparam int OPW_PRED_SEL = 7;
	localparam int PRED_W       = 6;
	localparam int PRED_NAWARE  = 4;      // bit set => ieee-nonaware test
	localparam int CC_NAN       = 0;      // nan bit of condition code
	localparam int CC_Z         = 2;
	localparam int CC_N         = 3;

	// extended nan layout: signaling bit is top fraction bit below j bit
	localparam int XNAN_W       = 80;
	localparam int XNAN_QBIT    = 62;

	// destination formats
	typedef enum logic [2:0] {
		FUSE_FMT_LONG = 3'b000,
		FUSE_FMT_SGL  = 3'b001,
		FUSE_FMT_EXT  = 3'b010,
		FUSE_FMT_PACK = 3'b011,
		FUSE_FMT_WORD = 3'b100,
		FUSE_FMT_DBL  = 3'b101,
		FUSE_FMT_BYTE = 3'b110
	} fuse_fmt_t;

	// instruction issue request
	typedef struct packed {
		logic        is_cond;      // fp_conditional_branch/fp_decrement_branch/fp_conditional_set/fp_conditional_trap
		logic        is_arith;     // arithmetic op (sets status)
		logic        is_nostat;    // multi move, ctrl move, state save
		logic        is_move_out;  // fp_move to memory / integer reg
		fuse_fmt_t   fmt;
		logic [15:0] opword;
		logic [15:0] extword;
		logic        src_signaling_nan;
		logic        dst_signaling_nan;
		logic        packed_inexact_flag;        // packed-inexact condition
		logic [7:0]  other_exc;    // other arith conditions, bits 5..1
	} fuse_req_t;

	// exception taken toward the sequencer
	typedef struct packed {
		logic       take;
		logic       post;
		logic [3:0] frame;
		logic [7:0] vector;
	} fuse_trap_t;

endpackage

// ---- fuse_unit.sv ----
/*
 * fuse_unit: exception sequencing for fp conditional tests (unordered
 * branch) and signaling-nan operands, with priority resolution.
 * assumes: issue requests held stable while issue_stall is high; the
 * pipeline reports idle on fp_idle; software status writes arrive on
 * sw_status_we.
 */
`timescale 1ns/1ns
module fuse_unit (
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	input  wire logic                clk_en,
	input  wire logic                req_valid,
	input  fuse_pkg::fuse_req_t      req,
	input  wire logic                fp_idle,
	input  wire logic [3:0]          fp_condition_code,
	input  wire logic [7:0]          fp_control_register,
	input  wire logic [fuse_pkg::XNAN_W-1:0] src_operand,
	input  wire logic [fuse_pkg::XNAN_W-1:0] dst_operand,
	input  wire logic                sw_status_we,
	input  wire logic [7:0]          sw_status_data,
	input  wire logic                trap_ack,
	output logic                     issue_stall,
	output logic                     req_done,
	output logic                     cond_result,
	output logic [fuse_pkg::XNAN_W-1:0] result_q,
	output logic                     result_valid_q,
	output logic [7:0]               exception_status_byte,
	output fuse_pkg::fuse_trap_t     trap_q,
	output logic [fuse_pkg::XNAN_W-1:0] exception_operand_field,
	output logic [fuse_pkg::XNAN_W-1:0] destination_operand_field
);
	import fuse_pkg::*;

	logic [7:0]        exc_q;
	logic              pend_q;        // posted maskable exception
	logic [7:0]        pend_vec_q;
	logic [XNAN_W-1:0] exception_operand_field_q;
	logic [XNAN_W-1:0] destination_operand_field_q;
	logic [PRED_W-1:0] pred;
	logic              naware;
	logic              unord_hit;
	logic              cond_ok;
	logic              cond_trap;
	logic              signaling_nan_in;
	logic              signaling_nan_mask;
	logic              signaling_nan_now;
	logic [7:0]        new_exc;
	logic [7:0]        fire;
	logic              accept;

	// pick the predicate field from the encoding
	function automatic logic [PRED_W-1:0] pick_pred(
		input logic [15:0] opw,
		input logic [15:0] extw
	);
		if (opw[OPW_PRED_SEL]) begin
			pick_pred = opw[PRED_W-1:0];
		end else begin
			pick_pred = extw[PRED_W-1:0];
		end
	endfunction

	// highest set bit wins; bit 7 of the byte is the top priority
	function automatic logic [7:0] top_bit(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (v[i]) begin
				r = 8'h00;
				r[i] = 1'b1;
			end
		end
		top_bit = r;
	endfunction

	// vector number for one-hot exception bit
	function automatic logic [7:0] vec_of(input logic [7:0] oh);
		if (oh[EXC_UNORD]) begin
			vec_of = VEC_UNORD;
		end else if (oh[EXC_SIGNALING_NAN]) begin
			vec_of = VEC_SIGNALING_NAN;
		end else if (oh[EXC_OPERAND_ERROR]) begin
			vec_of = VEC_OPERAND_ERROR;
		end else if (oh[EXC_OVFL]) begin
			vec_of = VEC_OVFL;
		end else if (oh[EXC_UNFL]) begin
			vec_of = VEC_UNFL;
		end else if (oh[EXC_DZ]) begin
			vec_of = VEC_DZ;
		end else begin
			vec_of = VEC_INEX;
		end
	endfunction

	// ieee-aware evaluation of the low four predicate bits
	function automatic logic eval_pred(
		input logic [PRED_W-1:0] p,
		input logic [3:0]        cc
	);
		logic n;
		logic z;
		logic u;
		logic gt;
		logic lt;
		n = cc[CC_N];
		z = cc[CC_Z];
		u = cc[CC_NAN];
		gt = !(n || z || u);
		lt = n && !(z || u);
		// bit3 unordered, bit2 greater, bit1 less, bit0 equal
		eval_pred = (p[3] && u) || (p[2] && gt) || (p[1] && lt)
			|| (p[0] && z && !u);
	endfunction

	// conditional test decode
	always_comb begin
		pred      = pick_pred(req.opword, req.extword);
		naware    = pred[PRED_NAWARE];
		unord_hit = naware && fp_condition_code[CC_NAN];
		cond_ok   = eval_pred(pred, fp_condition_code);
	end

	// a conditional op waits for a drained pipeline before it is accepted,
	// but cond_result is ungated and shows the predicate on a stale code meanwhile
	assign issue_stall = req_valid && req.is_cond && !fp_idle;

	// one-cycle accept of a request; pending traps block acceptance
	assign accept = clk_en && req_valid && !issue_stall && !trap_q.take
		&& !pend_q;

	// signaling_nan classification
	always_comb begin
		signaling_nan_in   = req.is_arith && (req.src_signaling_nan || req.dst_signaling_nan);
		signaling_nan_mask = !req.is_move_out || req.fmt == FUSE_FMT_SGL
			|| req.fmt == FUSE_FMT_DBL || req.fmt == FUSE_FMT_EXT;
		signaling_nan_now  = signaling_nan_in && req.is_move_out && (req.fmt ==
			FUSE_FMT_BYTE || req.fmt == FUSE_FMT_WORD ||
			req.fmt == FUSE_FMT_LONG);
	end

	// flags an accepted instruction raises; status-free ops raise none
	always_comb begin
		new_exc = 8'h00;
		if (req.is_cond) begin
			new_exc[EXC_UNORD] = unord_hit;
		end else if (req.is_arith && !req.is_nostat) begin
			new_exc = req.other_exc & 8'h3e;
			new_exc[EXC_SIGNALING_NAN]  = signaling_nan_in;
			new_exc[EXC_PACKED_INEXACT_FLAG] = req.packed_inexact_flag;
		end
	end

	// enabled flags, best first; the packed-inexact flag stays set but
	// loses to a simultaneous signaling_nan
	assign fire = top_bit(new_exc & fp_control_register);

	// exception status byte: hardware set wins over software write
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			exc_q <= 8'h00;
		end else if (clk_en) begin
			if (accept) begin
				exc_q <= (sw_status_we ? sw_status_data : exc_q) | new_exc;
			end else if (sw_status_we) begin
				exc_q <= sw_status_data;
			end
		end
	end
	assign exception_status_byte = exc_q;

	// posting of maskable exceptions; reported by the next fp op
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q     <= 1'b0;
			pend_vec_q <= 8'h00;
		end else if (clk_en) begin
			if (accept && !req.is_cond && !signaling_nan_now && |fire) begin
				pend_q     <= 1'b1;
				pend_vec_q <= vec_of(fire);
			end else if (pend_q && req_valid && !trap_q.take) begin
				pend_q <= 1'b0;  // converted into a trap below
			end
		end
	end

	// trap generation; held until the sequencer acknowledges
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			trap_q <= '0;
		end else if (clk_en) begin
			if (trap_q.take) begin
				if (trap_ack) begin
					trap_q <= '0;
				end
			end else if (pend_q && req_valid) begin
				trap_q.take   <= 1'b1;
				trap_q.post   <= 1'b0;
				trap_q.frame  <= FRAME_PRE;
				trap_q.vector <= pend_vec_q;
			end else if (accept && req.is_cond
				&& fire[EXC_UNORD]) begin
				trap_q.take   <= 1'b1;
				trap_q.post   <= 1'b0;
				trap_q.frame  <= FRAME_PRE;
				trap_q.vector <= VEC_UNORD;
			end else if (accept && signaling_nan_now) begin
				trap_q.take   <= 1'b1;
				trap_q.post   <= 1'b1;
				trap_q.frame  <= FRAME_POST;
				trap_q.vector <= VEC_SIGNALING_NAN;
			end
		end
	end

	// req_done only when no unordered trap, cond_result ungated; a retried op rechecks
	assign req_done = accept && !(req.is_cond && fire[EXC_UNORD]);
	assign cond_result = req.is_cond && cond_ok;

	// state frame operands keep their signaling bit untouched
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			exception_operand_field_q  <= '0;
			destination_operand_field_q <= '0;
		end else if (clk_en && accept && signaling_nan_in) begin
			exception_operand_field_q  <= src_operand;
			destination_operand_field_q <= dst_operand;
		end
	end
	assign exception_operand_field   = exception_operand_field_q;
	assign destination_operand_field = destination_operand_field_q;

	// masked signaling_nan: quiet the nan, all other bits unchanged
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			result_q       <= '0;
			result_valid_q <= 1'b0;
		end else if (clk_en) begin
			result_valid_q <= 1'b0;
			if (accept && signaling_nan_in && signaling_nan_mask
				&& !fp_control_register[EXC_SIGNALING_NAN]) begin
				result_q <= req.src_signaling_nan ? src_operand : dst_operand;
				result_q[XNAN_QBIT] <= 1'b1;
				result_valid_q <= 1'b1;
			end
		end
	end

endmodule

// ---- fuse_unit_checker.sv ----
/* fuse_unit_checker: port-level assertions for the fp exception unit.
   assumes: bound to fuse_unit, one clock domain, clk_en mostly high. */
`timescale 1ns/1ns
module fuse_unit_checker
	import fuse_pkg::*;
(
	input wire logic          core_clk,
	input wire logic          arst_n,
	input wire logic          clk_en,
	input wire logic          req_valid,
	input fuse_pkg::fuse_req_t req,
	input wire logic          fp_idle,
	input wire logic [3:0]    fp_condition_code,
	input wire logic [7:0]    fp_control_register,
	input wire logic          sw_status_we,
	input wire logic          trap_ack,
	input wire logic          issue_stall,
	input wire logic          req_done,
	input wire logic [7:0]    exception_status_byte,
	input fuse_pkg::fuse_trap_t trap_q
);
	logic [5:0] pred;
	logic       acc;

	// predicate source and acceptance as seen from the ports
	assign pred = req.opword[7] ? req.opword[5:0] : req.extword[5:0];
	assign acc = clk_en && req_valid && !issue_stall && !trap_q.take;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_unord;
		acc && req.is_cond && pred[PRED_NAWARE] && fp_condition_code[CC_NAN];
	endsequence
	sequence s_pre_trap;
		trap_q.take && !trap_q.post && trap_q.frame == FRAME_PRE;
	endsequence

	a_stall_drain: assert property (
		issue_stall == (req_valid && req.is_cond && !fp_idle))
		else $error("stall does not follow pipeline idle");
	a_unord_flag: assert property (s_unord |=>
		exception_status_byte[EXC_UNORD] || trap_q.take)
		else $error("unordered flag not set");
	a_unord_trap: assert property (
		s_unord ##0 fp_control_register[EXC_UNORD] |=> s_pre_trap)
		else $error("unordered trap missing");
	a_unord_first: assert property (
		s_unord ##0 fp_control_register[EXC_UNORD] |-> !req_done)
		else $error("conditional completed despite trap");
	a_unord_mask: assert property (
		$rose(trap_q.take) && trap_q.vector == VEC_UNORD
		|-> !trap_q.post && $past(fp_control_register[EXC_UNORD]))
		else $error("unordered trap without enable");
	a_signaling_nan_flag: assert property (clk_en && req_done && req.is_arith &&
		(req.src_signaling_nan || req.dst_signaling_nan) |=> exception_status_byte[EXC_SIGNALING_NAN])
		else $error("signaling_nan flag not set");
	a_signaling_nan_post: assert property (clk_en && req_done &&
		req.is_arith && req.is_move_out && req.src_signaling_nan && req.fmt inside
		{FUSE_FMT_BYTE, FUSE_FMT_WORD, FUSE_FMT_LONG} |=> trap_q.take &&
		trap_q.post && trap_q.frame == FRAME_POST && trap_q.vector == VEC_SIGNALING_NAN)
		else $error("integer signaling_nan move not trapped");
	a_nostat_keep: assert property (clk_en && req_done &&
		req.is_nostat && !sw_status_we
		|=> $stable(exception_status_byte) && !$rose(trap_q.take))
		else $error("status-free op changed status");
	a_sw_notrap: assert property (
		sw_status_we && !req_valid && !trap_q.take |=> !trap_q.take)
		else $error("software write raised a trap");
	a_trap_hold: assert property (
		trap_q.take && !trap_ack |=> $stable(trap_q))
		else $error("trap dropped before acknowledge");
endmodule

bind fuse_unit fuse_unit_checker fuse_unit_checker_inst (.core_clk, .arst_n,
	.clk_en, .req_valid, .req, .fp_idle, .fp_condition_code,
	.fp_control_register, .sw_status_we, .trap_ack, .issue_stall,
	.req_done, .exception_status_byte, .trap_q);

// ---- fuse_unit_bench.sv ----
/* fuse_unit_bench: directed test of the fp exception unit.
   assumes: fuse_pkg compiled first; inputs change on falling edges. */
`timescale 1ns/1ns
module fuse_unit_bench;
	import fuse_pkg::*;
	logic        core_clk = 0, arst_n = 0, clk_en = 1, req_valid = 0;
	logic        fp_idle = 1, sw_status_we = 0, trap_ack = 0;
	logic [3:0]  fp_condition_code = 0;
	logic [7:0]  fp_control_register = 0, sw_status_data = 0;
	logic [7:0]  exception_status_byte;
	logic [79:0] src_operand = 80'h7fff_a000_0000_0000_0001;
	logic [79:0] dst_operand = 0, result_q;
	logic [79:0] exception_operand_field, destination_operand_field;
	logic        issue_stall, req_done, cond_result, result_valid_q;
	fuse_req_t   req = '0, r, rc;
	fuse_trap_t  trap_q;
	fuse_fmt_t   fm[3] = '{FUSE_FMT_BYTE, FUSE_FMT_WORD, FUSE_FMT_LONG};
	int          n_errors = 0, total_checks = 0, cycles = 0;

	fuse_unit fuse_unit_inst (.core_clk, .arst_n, .clk_en, .req_valid, .req,
		.fp_idle, .fp_condition_code, .fp_control_register, .src_operand,
		.dst_operand, .sw_status_we, .sw_status_data, .trap_ack,
		.issue_stall, .req_done, .cond_result, .result_q, .result_valid_q,
		.exception_status_byte, .trap_q, .exception_operand_field,
		.destination_operand_field);

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	task automatic chk(input string n, input logic [79:0] e,
		input logic [79:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// one request held for a single accepting edge
	task automatic send(input fuse_req_t q, input logic d);
		@(negedge core_clk);
		req = q;
		req_valid = 1;
		#1 chk("req_done", d, req_done);
		@(negedge core_clk);
		req_valid = 0;
	endtask

	// compare the taken trap, then acknowledge it
	task automatic trap(input logic p, input logic [7:0] v);
		chk("trap", {1'b1, p, p ? FRAME_POST : FRAME_PRE, v}, trap_q);
		@(negedge core_clk) trap_ack = 1;
		@(negedge core_clk) trap_ack = 0;
	endtask

	task automatic sw(input logic [7:0] d);
		@(negedge core_clk);
		sw_status_we = 1;
		sw_status_data = d;
		@(negedge core_clk) sw_status_we = 0;
	endtask

	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard: the sequence needs well under 400 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		repeat (20) @(negedge core_clk);
		arst_n = 1;
		chk("status", 0, exception_status_byte);
		chk("trap", 0, trap_q);
		// nonaware predicate from the extension word, pipeline busy
		r = '0;
		r.is_cond = 1;
		r.extword = 16'h0010;
		rc = r;
		fp_idle = 0;
		@(negedge core_clk);
		req = r;
		req_valid = 1;
		repeat (3) begin
			#1 chk("stall", 1, issue_stall);
			chk("req_done", 0, req_done);
			@(negedge core_clk);
		end
		fp_idle = 1;
		#1 chk("req_done", 1, req_done);
		@(negedge core_clk) req_valid = 0;
		// unordered with the exception disabled, then enabled
		fp_condition_code = 4'h1;
		send(r, 1);
		chk("status", 8'h80, exception_status_byte);
		chk("trap", 0, trap_q.take);
		fp_control_register = 8'h80;
		send(r, 0);
		trap(0, VEC_UNORD);
		send(r, 0);
		trap(0, VEC_UNORD);
		r.opword = 16'h0080; // aware predicate in the operation word
		send(r, 1);
		chk("trap", 0, trap_q.take);
		// quieting of a signaling source into a data register
		sw(0);
		fp_control_register = 0;
		fp_condition_code = 0;
		r = '0;
		r.is_arith = 1;
		r.src_signaling_nan = 1;
		r.fmt = FUSE_FMT_EXT;
		send(r, 1);
		chk("signaling_nan flag", 1, exception_status_byte[EXC_SIGNALING_NAN]);
		chk("result valid", 1, result_valid_q);
		chk("result", src_operand ^ 80'h0000_4000_0000_0000_0000, result_q);
		// posted signaling_nan reported before the next conditional
		fp_control_register = 8'h40;
		send(r, 1);
		chk("trap", 0, trap_q.take);
		send(rc, 0);
		trap(0, VEC_SIGNALING_NAN);
		// integer-format moves trap at once, hiding packed inexact
		fp_control_register = 8'h41;
		r.is_move_out = 1;
		r.packed_inexact_flag = 1;
		foreach (fm[i]) begin
			r.fmt = fm[i];
			send(r, 1);
			chk("operand field", src_operand, exception_operand_field);
			trap(1, VEC_SIGNALING_NAN);
		end
		r.fmt = FUSE_FMT_DBL;
		send(r, 1);
		chk("trap", 0, trap_q.take);
		send(rc, 0);
		trap(0, VEC_SIGNALING_NAN);
		// status-free op and software flag write
		sw(0);
		fp_control_register = 8'hff;
		r = '0;
		r.is_nostat = 1;
		r.src_signaling_nan = 1;
		send(r, 1);
		chk("status", 0, exception_status_byte);
		sw(8'hff);
		chk("trap", 0, trap_q.take);
		chk("status", 8'hff, exception_status_byte);
		// clock enable low freezes the status byte against a write
		clk_en = 0;
		sw(8'h00);
		chk("status", 8'hff, exception_status_byte);
		@(negedge core_clk) clk_en = 1;
		results();
	end
endmodule
